// ---- pkg/dbgcu_pkg.sv ----
// dbgcu_pkg: command codes, register layouts, memory spaces and states of the debug command unit
// assumes: a byte-wide command stream from the serial link layer on the system clock
package dbgcu_pkg;
  // command bytes
  localparam logic [7:0] CMD_VERSION = 8'h00;
  localparam logic [7:0] CMD_STATUS  = 8'h02;
  localparam logic [7:0] CMD_RUNTIME = 8'h03;
  localparam logic [7:0] CMD_CTL_WR  = 8'h04;
  localparam logic [7:0] CMD_CTL_RD  = 8'h05;
  localparam logic [7:0] CMD_PC_WR   = 8'h06;
  localparam logic [7:0] CMD_PC_RD   = 8'h07;
  localparam logic [7:0] CMD_REG_WR  = 8'h08;
  localparam logic [7:0] CMD_REG_RD  = 8'h09;
  localparam logic [7:0] CMD_PROG_WR = 8'h0a;
  localparam logic [7:0] CMD_PROG_RD = 8'h0b;
  localparam logic [7:0] CMD_DATA_WR = 8'h0c;
  localparam logic [7:0] CMD_DATA_RD = 8'h0d;
  localparam logic [7:0] CMD_CRC     = 8'h0e;
  localparam logic [7:0] CMD_STEP    = 8'h10;
  localparam logic [7:0] CMD_STUFF   = 8'h11;
  localparam logic [7:0] CMD_EXEC    = 8'h12;
  // debugger_control fields
  localparam int         CTL_DBG_BIT = 7;
  localparam int         CTL_BRK_BIT = 6;
  localparam int         CTL_ACK_BIT = 5;
  localparam int         CTL_RST_BIT = 0;
  localparam logic [7:0] CTL_RESET   = 8'h00;
  // debugger_status fields
  localparam int         STAT_DBG_BIT   = 7;
  localparam int         STAT_HALT_BIT  = 6;
  localparam int         STAT_RPOFF_BIT = 5;
  // data values
  localparam logic [7:0]  ACK_BYTE    = 8'hff;
  localparam logic [7:0]  BLANK_BYTE  = 8'hff;
  localparam logic [15:0] BLANK_WORD  = 16'hffff;
  localparam logic [15:0] CNT_MAX     = 16'hffff;
  localparam logic [15:0] CNT_RESET   = 16'h0000;
  localparam logic [15:0] CNT_LAST    = 16'h0001;
  localparam logic [15:0] REG_SIZE_0  = 16'h0100;
  localparam logic [15:0] CRC_POLY    = 16'h1021;
  localparam logic [15:0] CRC_INIT    = 16'hffff;
  // flash control register window, the only register writes kept under read protection
  localparam logic [11:0] FLASH_CTL_FIRST = 12'hff8;
  localparam logic [11:0] FLASH_CTL_LAST  = 12'hffd;

  typedef enum logic [1:0] {SP_REG = 2'h0, SP_PROG = 2'h1, SP_DATA = 2'h2} dbgcu_space_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_ARGS = 3'h1,
    S_XFER = 3'h3,
    S_SEND = 3'h2,
    S_CRC  = 3'h6,
    S_EXEC = 3'h7
  } dbgcu_state_t;
endpackage

// ---- rtl/dbgcu_crc16.sv ----
// dbgcu_crc16: bytewise 16-bit ccitt crc accumulator
// assumes: clear and enable come from the command unit on the same clock
`timescale 1ns/100ps
`default_nettype none
module dbgcu_crc16
  import dbgcu_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // control
  input  wire logic        i_clear,
  input  wire logic        i_en,
  input  wire logic [7:0]  i_byte,
  // result
  output logic      [15:0] o_crc,
  output logic      [15:0] o_crc_next
);
  logic [15:0] crc_reg;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  assign o_crc_next = crc_step(crc_reg, i_byte);
  assign o_crc      = crc_reg;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || i_clear) begin
      crc_reg <= CRC_INIT;
    end else if (i_en) begin
      crc_reg <= o_crc_next;
    end
  end
endmodule // dbgcu_crc16
`default_nettype wire

// ---- rtl/dbgcu_top.sv ----
// dbgcu_top: debug command unit, interprets host command bytes and drives cpu and memory ports
// assumes: byte stream from the serial link layer and cpu/memory ports on the same clock
// Contract
// - version two bytes major first; status one byte
// - 16-bit saturating runtime counter, read high first
// - commands may overwrite the runtime counter
// - control write/read; protection keeps debug mode set
// - pc write only in debug unprotected
// - pc read gives all ones when gated
// - register write framing; protection allows flash control
// - register read framing; gated reads all ones
// - program write needs unlock, debug, no protection
// - program read gated returns all ones
// - data write only in debug unprotected
// - data read works protected, blank outside debug
// - crc of program memory, ones outside debug
// - step only in debug unprotected
// - stuff supplies first opcode byte, gated likewise
// - execute forwards instruction; gated eats one byte
// - debug mode stops cpu; break sets it
// - breakpoint enable resets zero; gates break
// - acknowledge byte sent on breakpoint when acknowledge enable is set
// - reset bit self-clears; bits four-one read zero
// - combined control writes work as written
// - status shows debug, halt, protection-off
`timescale 1ns/100ps
`default_nettype none
module dbgcu_top
  import dbgcu_pkg::*;
#(
  parameter logic [15:0] VERSION_CODE = 16'h0100, // arbitrary value
  parameter int          PROG_BYTES   = 8192
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // host byte stream
  input  wire logic        i_rx_valid,
  input  wire logic [7:0]  i_rx_data,
  output logic             o_rx_ready,
  output logic             o_tx_valid,
  output logic      [7:0]  o_tx_data,
  input  wire logic        i_tx_ready,
  // protection
  input  wire logic        i_read_protect_option,
  input  wire logic        i_flash_unlocked,
  // cpu
  input  wire logic [15:0] i_cpu_pc,
  input  wire logic        i_cpu_halted,
  input  wire logic        i_break_decoded,
  input  wire logic        i_inject_last,
  input  wire logic        i_sys_reset_done,
  output logic             o_cpu_stop,
  output logic             o_pc_load,
  output logic      [15:0] o_pc_value,
  output logic             o_step,
  output logic             o_stuff,
  output logic             o_inject,
  output logic      [7:0]  o_instr_byte,
  output logic             o_sys_reset_req,
  // memory
  output logic             o_mem_req,
  output logic             o_mem_we,
  output dbgcu_space_t     o_mem_space,
  output logic      [15:0] o_mem_addr,
  output logic      [7:0]  o_mem_wdata,
  input  wire logic        i_mem_ack,
  input  wire logic [7:0]  i_mem_rdata
);
  if (PROG_BYTES < 1 || PROG_BYTES > 65536) begin : g_bad_prog_bytes
    $error("PROG_BYTES out of range");
  end
  localparam logic [15:0] PROG_CNT = 16'(PROG_BYTES);

  dbgcu_state_t state_reg;
  logic [7:0]   cmd_reg;
  logic [23:0]  args_reg;
  logic [2:0]   argc_reg;
  logic [15:0]  addr_reg, cnt_reg, resp_reg, crc_val, crc_next;
  logic [1:0]   nb_reg;
  logic         dbg_reg, brk_reg, acken_reg, rst_reg, dbg_prev_reg, ack_pend_reg;
  logic         wr_reg, mem_req_reg, tx_valid_reg;
  logic [7:0]   tx_data_reg;
  logic         rx_acc, last_arg, ctl_wr, brk_event, free_ok, ok_now, xfer_issue, xfer_step;
  logic         mem_done, cnt_load, cnt_dec, tx_load, crc_clear;
  logic [15:0]  cnt_load_val;
  logic [31:0]  full;
  logic [7:0]   tx_byte, status_byte, ctl_byte;

  function automatic logic [2:0] arg_count(input logic [7:0] c);
    unique case (c)
      CMD_CTL_WR, CMD_STUFF, CMD_EXEC:                      return 3'h1;
      CMD_PC_WR:                                            return 3'h2;
      CMD_REG_WR, CMD_REG_RD:                               return 3'h3;
      CMD_PROG_WR, CMD_PROG_RD, CMD_DATA_WR, CMD_DATA_RD:   return 3'h4;
      default:                                              return 3'h0;
    endcase
  endfunction

  function automatic logic allowed(input logic [7:0] c, input logic d, input logic rp,
                                   input logic unl, input logic [11:0] a);
    unique case (c)
      CMD_REG_WR:               return d && (!rp || (a >= FLASH_CTL_FIRST && a <= FLASH_CTL_LAST));
      CMD_REG_RD, CMD_PROG_RD:  return d && !rp;
      CMD_PROG_WR:              return d && !rp && unl;
      CMD_DATA_WR:              return d && !rp;
      CMD_DATA_RD:              return d;
      default:                  return 1'b0;
    endcase
  endfunction

  // combinational decode
  assign rx_acc      = i_rx_valid && o_rx_ready;
  assign last_arg    = (state_reg == S_ARGS) && rx_acc && (argc_reg == 3'h1);
  assign full        = {args_reg, i_rx_data};
  assign ctl_wr      = last_arg && (cmd_reg == CMD_CTL_WR);
  assign brk_event   = i_break_decoded && brk_reg;
  assign free_ok     = dbg_reg && !i_read_protect_option;
  assign ok_now      = allowed(cmd_reg, dbg_reg, i_read_protect_option, i_flash_unlocked, addr_reg[11:0]);
  assign mem_done    = mem_req_reg && i_mem_ack;
  assign xfer_issue  = (state_reg == S_XFER) &&
                       (wr_reg ? rx_acc : (!tx_valid_reg && !mem_req_reg));
  assign xfer_step   = (state_reg == S_XFER) && (ok_now ? mem_done : xfer_issue);
  assign status_byte = {dbg_reg, i_cpu_halted, !i_read_protect_option, 5'h00};
  assign ctl_byte    = {dbg_reg, brk_reg, acken_reg, 4'h0, rst_reg};
  assign crc_clear   = (state_reg == S_IDLE) && rx_acc && (i_rx_data == CMD_CRC) && dbg_reg;

  always_comb begin
    unique case (state_reg)
      S_IDLE:         o_rx_ready = !ack_pend_reg;
      S_ARGS, S_EXEC: o_rx_ready = 1'b1;
      S_XFER:         o_rx_ready = wr_reg && !mem_req_reg;
      default:        o_rx_ready = 1'b0;
    endcase
  end

  // runtime counter doubles as transfer byte counter
  always_comb begin
    cnt_load     = 1'b0;
    cnt_load_val = CNT_RESET;
    if (last_arg && arg_count(cmd_reg) == 3'h3) begin
      cnt_load     = 1'b1;
      cnt_load_val = (full[7:0] == 8'h00) ? REG_SIZE_0 : {8'h00, full[7:0]};
    end else if (last_arg && arg_count(cmd_reg) == 3'h4) begin
      cnt_load     = 1'b1;
      cnt_load_val = full[15:0];
    end else if (crc_clear) begin
      cnt_load     = 1'b1;
      cnt_load_val = PROG_CNT;
    end
  end
  assign cnt_dec = xfer_step || ((state_reg == S_CRC) && mem_done);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_reg      <= CNT_RESET;
      dbg_prev_reg <= 1'b0;
    end else begin
      dbg_prev_reg <= dbg_reg;
      if (cnt_load) begin
        cnt_reg <= cnt_load_val;
      end else if (cnt_dec) begin
        cnt_reg <= cnt_reg - 16'h0001;
      end else if (dbg_prev_reg && !dbg_reg) begin
        cnt_reg <= CNT_RESET;
      end else if (!dbg_reg && state_reg != S_XFER && cnt_reg != CNT_MAX) begin
        cnt_reg <= cnt_reg + 16'h0001;
      end
    end
  end

  // control register
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      {dbg_reg, brk_reg, acken_reg, rst_reg} <= {CTL_RESET[7:5], CTL_RESET[0]};
      ack_pend_reg <= 1'b0;
    end else begin
      if (ctl_wr) begin
        dbg_reg   <= i_read_protect_option ? (dbg_reg | i_rx_data[CTL_DBG_BIT]) : i_rx_data[CTL_DBG_BIT];
        brk_reg   <= i_rx_data[CTL_BRK_BIT];
        acken_reg <= i_rx_data[CTL_ACK_BIT];
        rst_reg   <= i_rx_data[CTL_RST_BIT];
      end else if (i_sys_reset_done) begin
        rst_reg <= 1'b0;
      end
      if (brk_event) begin
        dbg_reg <= 1'b1;
      end
      if (brk_event && acken_reg) begin
        ack_pend_reg <= 1'b1;
      end else if (state_reg == S_IDLE && !tx_valid_reg) begin
        ack_pend_reg <= 1'b0;
      end
    end
  end

  // answer bytes
  always_comb begin
    tx_load = 1'b0;
    tx_byte = BLANK_BYTE;
    unique case (state_reg)
      S_IDLE: begin
        tx_load = ack_pend_reg && !tx_valid_reg;
        tx_byte = ACK_BYTE;
      end
      S_SEND: begin
        tx_load = !tx_valid_reg;
        tx_byte = (nb_reg == 2'h2) ? resp_reg[15:8] : resp_reg[7:0];
      end
      S_XFER: begin
        tx_load = !wr_reg && (ok_now ? mem_done : xfer_issue);
        tx_byte = ok_now ? i_mem_rdata : BLANK_BYTE;
      end
      default: begin
        tx_load = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tx_valid_reg <= 1'b0;
      tx_data_reg  <= 8'h00;
    end else if (tx_load) begin
      tx_valid_reg <= 1'b1;
      tx_data_reg  <= tx_byte;
    end else if (i_tx_ready) begin
      tx_valid_reg <= 1'b0;
    end
  end

  // memory request
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      mem_req_reg <= 1'b0;
      o_mem_we    <= 1'b0;
      o_mem_wdata <= 8'h00;
    end else if (mem_done) begin
      mem_req_reg <= 1'b0;
    end else if ((xfer_issue && ok_now) || (state_reg == S_CRC && !mem_req_reg)) begin
      mem_req_reg <= 1'b1;
      o_mem_we    <= (state_reg == S_XFER) && wr_reg;
      o_mem_wdata <= i_rx_data;
    end
  end

  dbgcu_crc16 u_crc (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_clear    (crc_clear),
    .i_en       ((state_reg == S_CRC) && mem_done),
    .i_byte     (i_mem_rdata),
    .o_crc      (crc_val),
    .o_crc_next (crc_next)
  );

  // command sequencer
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_reg   <= S_IDLE;
      cmd_reg     <= 8'h00;
      args_reg    <= 24'h000000;
      argc_reg    <= 3'h0;
      addr_reg    <= 16'h0000;
      resp_reg    <= 16'h0000;
      nb_reg      <= 2'h0;
      wr_reg      <= 1'b0;
      o_mem_space <= SP_REG;
      o_pc_load   <= 1'b0;
      o_pc_value  <= 16'h0000;
      o_step      <= 1'b0;
      o_stuff     <= 1'b0;
      o_inject    <= 1'b0;
      o_instr_byte <= 8'h00;
    end else begin
      o_pc_load <= 1'b0;
      o_step    <= 1'b0;
      o_stuff   <= 1'b0;
      o_inject  <= 1'b0;
      unique case (state_reg)
        S_IDLE: if (rx_acc) begin
          cmd_reg  <= i_rx_data;
          argc_reg <= arg_count(i_rx_data);
          nb_reg   <= 2'h2;
          state_reg <= S_SEND;
          unique case (i_rx_data)
            CMD_VERSION: resp_reg <= VERSION_CODE;
            CMD_RUNTIME: resp_reg <= cnt_reg;
            CMD_PC_RD:   resp_reg <= free_ok ? i_cpu_pc : BLANK_WORD;
            CMD_STATUS: begin
              resp_reg <= {8'h00, status_byte};
              nb_reg   <= 2'h1;
            end
            CMD_CTL_RD: begin
              resp_reg <= {8'h00, ctl_byte};
              nb_reg   <= 2'h1;
            end
            CMD_CRC: begin
              addr_reg    <= 16'h0000;
              o_mem_space <= SP_PROG;
              resp_reg  <= BLANK_WORD;
              state_reg <= dbg_reg ? S_CRC : S_SEND;
            end
            CMD_STEP: begin
              o_step    <= free_ok;
              state_reg <= S_IDLE;
            end
            default: state_reg <= (arg_count(i_rx_data) != 3'h0) ? S_ARGS : S_IDLE;
          endcase
        end
        S_ARGS: if (rx_acc) begin
          args_reg <= full[23:0];
          argc_reg <= argc_reg - 3'h1;
          if (argc_reg == 3'h1) begin
            state_reg   <= S_IDLE;
            wr_reg      <= !cmd_reg[0];
            o_mem_space <= (cmd_reg[3:1] == 3'h4) ? SP_REG : (cmd_reg[3:1] == 3'h5) ? SP_PROG : SP_DATA;
            if (arg_count(cmd_reg) == 3'h3) begin
              addr_reg  <= {4'h0, full[19:8]};
              state_reg <= S_XFER;
            end else if (arg_count(cmd_reg) == 3'h4) begin
              addr_reg  <= full[31:16];
              state_reg <= S_XFER;
            end
            if (cmd_reg == CMD_PC_WR) begin
              o_pc_load  <= free_ok;
              o_pc_value <= full[15:0];
            end
            if (cmd_reg == CMD_STUFF || cmd_reg == CMD_EXEC) begin
              o_instr_byte <= i_rx_data;
              o_stuff      <= free_ok && (cmd_reg == CMD_STUFF);
              o_inject     <= free_ok && (cmd_reg == CMD_EXEC);
              if (free_ok && cmd_reg == CMD_EXEC && !i_inject_last) begin
                state_reg <= S_EXEC;
              end
            end
          end
        end
        S_XFER: if (xfer_step) begin
          addr_reg <= addr_reg + 16'h0001;
          if (cnt_reg == CNT_LAST) begin
            state_reg <= S_IDLE;
          end
        end
        S_CRC: if (mem_done) begin
          addr_reg <= addr_reg + 16'h0001;
          if (cnt_reg == CNT_LAST) begin
            resp_reg  <= crc_next;
            nb_reg    <= 2'h2;
            state_reg <= S_SEND;
          end
        end
        S_SEND: if (!tx_valid_reg) begin
          nb_reg <= nb_reg - 2'h1;
          if (nb_reg == 2'h1) begin
            state_reg <= S_IDLE;
          end
        end
        S_EXEC: if (rx_acc) begin
          o_inject     <= 1'b1;
          o_instr_byte <= i_rx_data;
          if (i_inject_last) begin
            state_reg <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  assign o_tx_valid      = tx_valid_reg;
  assign o_tx_data       = tx_data_reg;
  assign o_cpu_stop      = dbg_reg;
  assign o_sys_reset_req = rst_reg;
  assign o_mem_req       = mem_req_reg;
  assign o_mem_addr      = addr_reg;

  property p_ver;
    @(posedge i_clk) disable iff (!i_rst_n)
    (state_reg == S_SEND && tx_load && nb_reg == 2'h2 && cmd_reg == CMD_VERSION) |=> o_tx_data == VERSION_CODE[15:8];
  endproperty
  a_ver: assert property (p_ver) else $error("version high byte wrong");
  property p_sat;
    @(posedge i_clk) disable iff (!i_rst_n)
    (cnt_reg == CNT_MAX && !cnt_load && !cnt_dec && dbg_prev_reg == dbg_reg) |=> cnt_reg == CNT_MAX;
  endproperty
  a_sat: assert property (p_sat) else $error("runtime counter wrapped");
  property p_keep;
    @(posedge i_clk) disable iff (!i_rst_n) (i_read_protect_option && dbg_reg) |=> dbg_reg;
  endproperty
  a_keep: assert property (p_keep) else $error("debug mode cleared under protection");
  property p_pcw;
    @(posedge i_clk) disable iff (!i_rst_n) o_pc_load |-> $past(free_ok);
  endproperty
  a_pcw: assert property (p_pcw) else $error("pc loaded while gated");
  property p_pcr;
    @(posedge i_clk) disable iff (!i_rst_n)
    (state_reg == S_IDLE && rx_acc && i_rx_data == CMD_PC_RD && !free_ok) |=> resp_reg == BLANK_WORD;
  endproperty
  a_pcr: assert property (p_pcr) else $error("gated pc read not blank");
  property p_rdb;
    @(posedge i_clk) disable iff (!i_rst_n)
    (state_reg == S_XFER && tx_load && !ok_now) |=> o_tx_valid && o_tx_data == BLANK_BYTE;
  endproperty
  a_rdb: assert property (p_rdb) else $error("gated read not blank");
  property p_wr;
    @(posedge i_clk) disable iff (!i_rst_n) ($rose(o_mem_req) && o_mem_we) |-> $past(ok_now && dbg_reg);
  endproperty
  a_wr: assert property (p_wr) else $error("gated memory write issued");
  property p_step;
    @(posedge i_clk) disable iff (!i_rst_n) (o_step || o_stuff) |-> $past(free_ok);
  endproperty
  a_step: assert property (p_step) else $error("step while gated");
  property p_brk;
    @(posedge i_clk) disable iff (!i_rst_n) brk_event |=> dbg_reg ##1 o_cpu_stop;
  endproperty
  a_brk: assert property (p_brk) else $error("break did not stop cpu");
  property p_nobrk;
    @(posedge i_clk) disable iff (!i_rst_n) (!brk_reg && !ctl_wr && !dbg_reg) |=> !dbg_reg;
  endproperty
  a_nobrk: assert property (p_nobrk) else $error("break taken while disabled");
  property p_rsv;
    @(posedge i_clk) disable iff (!i_rst_n)
    (state_reg == S_IDLE && rx_acc && i_rx_data >= 8'h13) |=> state_reg == S_IDLE && !o_mem_req;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved command acted");
  c_crc: cover property (@(posedge i_clk) state_reg == S_CRC ##[1:1000] state_reg == S_SEND);
  c_wr:  cover property (@(posedge i_clk) o_mem_req && o_mem_we && i_mem_ack);
  c_ack: cover property (@(posedge i_clk) brk_event && acken_reg);
endmodule // dbgcu_top
`default_nettype wire

// ---- bench/dbgcu_host.sv ----
// dbgcu_host: debug host adapter model on the byte stream
// assumes: shares the command unit clock; tasks are called from the bench
`timescale 1ns/100ps
`default_nettype none
module dbgcu_host (
  // clock and pacing
  input  wire logic       i_clk,
  input  wire logic       i_slow,
  // byte stream
  output logic            o_valid,
  output logic      [7:0] o_data,
  input  wire logic       i_ready,
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  output logic            o_tx_ready
);
  logic hung = 1'b0;
  initial begin
    o_valid = 1'b0;
    o_data = 8'h00;
    o_tx_ready = 1'b1;
  end
  // slow host takes answers only every other cycle
  always @(posedge i_clk) o_tx_ready <= i_slow ? ~o_tx_ready : 1'b1;
  // byte held until taken, then line shows the inverse
  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    @(posedge i_clk);
    o_valid <= 1'b1;
    o_data <= b;
    do begin
      @(posedge i_clk);
      n++;
    end while (!i_ready && n < 500);
    if (n == 500) hung = 1'b1;
    o_valid <= 1'b0;
    o_data <= ~b;
  endtask
  task automatic recv(output logic [7:0] b);
    int n;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (!(i_tx_valid && o_tx_ready) && n < 5000);
    if (n == 5000) hung = 1'b1;
    b = i_tx_data;
  endtask
endmodule // dbgcu_host
`default_nettype wire

// ---- bench/tb_dbgcu_top.sv ----
// tb_dbgcu_top: self-checking bench for the debug command unit
// assumes: host model dbgcu_host; memory and cpu answered here
`timescale 1ns/100ps
`default_nettype none
module tb_dbgcu_top
  import dbgcu_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, slow = 1'b0, prot = 1'b0, halted = 1'b0, break_opcode = 1'b0, rdone = 1'b0;
  logic [15:0] pc = 16'habcd;
  logic rxv, rxr, txv, txr, stop, load, step, stuff, inj, sreq, req, we, ack = 1'b0;
  logic [7:0] rxd, txd, instr, wd, rd = 8'h00, ins_seen = 8'h00;
  logic [15:0] pcv, addr;
  logic unl = 1'b0, ilast = 1'b1;
  logic [1:0] sp_last = 2'h0;
  logic [23:0] wr_last = 24'h0;
  dbgcu_space_t space;
  int n_step = 0, n_stuff = 0, n_load = 0, n_inj = 0, fail_count = 0, comparisons = 0;
  initial forever #2 clk = ~clk;
  dbgcu_top #(.VERSION_CODE(16'h1234), .PROG_BYTES(4)) i_dut (.i_clk(clk), .i_rst_n(rst_n),
    .i_rx_valid(rxv), .i_rx_data(rxd), .o_rx_ready(rxr), .o_tx_valid(txv), .o_tx_data(txd),
    .i_tx_ready(txr), .i_read_protect_option(prot), .i_flash_unlocked(unl), .i_cpu_pc(pc),
    .i_cpu_halted(halted), .i_break_decoded(break_opcode), .i_inject_last(ilast), .i_sys_reset_done(rdone),
    .o_cpu_stop(stop), .o_pc_load(load), .o_pc_value(pcv), .o_step(step), .o_stuff(stuff),
    .o_inject(inj), .o_instr_byte(instr), .o_sys_reset_req(sreq), .o_mem_req(req), .o_mem_we(we),
    .o_mem_space(space), .o_mem_addr(addr), .o_mem_wdata(wd), .i_mem_ack(ack), .i_mem_rdata(rd));
  dbgcu_host i_host (.i_clk(clk), .i_slow(slow), .o_valid(rxv), .o_data(rxd), .i_ready(rxr),
    .i_tx_valid(txv), .i_tx_data(txd), .o_tx_ready(txr));
  // memory answers a cycle late with address-derived data; cpu strobes counted
  always @(posedge clk) begin
    ack <= req & ~ack;
    rd <= addr[7:0] ^ 8'h5a;
    if (req & we & ack) wr_last <= {addr, wd};
    n_step <= n_step + int'(step);
    n_stuff <= n_stuff + int'(stuff);
    n_load <= n_load + int'(load);
    n_inj <= n_inj + int'(inj);
    if (req & ack) sp_last <= space;
    if (load) pc <= pcv;
    if (stuff | inj) ins_seen <= instr;
  end
  task automatic chk(input string n, input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic ex(input logic [7:0] e);
    logic [7:0] b;
    i_host.recv(b);
    chk("answer byte", {16'h0, b}, {16'h0, e});
  endtask
  task automatic r16(input logic [15:0] e);
    ex(e[15:8]);
    ex(e[7:0]);
  endtask
  task automatic w16(input logic [15:0] v);
    i_host.send(v[15:8]);
    i_host.send(v[7:0]);
  endtask
  task automatic ctl(input logic [7:0] v, input logic [7:0] e);
    i_host.send(CMD_CTL_WR);
    i_host.send(v);
    i_host.send(CMD_CTL_RD);
    ex(e);
  endtask
  task automatic mem(input logic [7:0] c, input logic [15:0] a, input logic [15:0] n);
    i_host.send(c);
    w16(a);
    w16(n);
  endtask
  task automatic strobe(input bit which);
    @(posedge clk);
    if (which) break_opcode <= 1'b1;
    else rdone <= 1'b1;
    @(posedge clk);
    break_opcode <= 1'b0;
    rdone <= 1'b0;
  endtask
  function automatic logic [15:0] crc_of(input int n);
    logic [15:0] c;
    c = 16'hffff;
    for (int k = 0; k < n; k++) begin
      c = c ^ {8'(k) ^ 8'h5a, 8'h00};
      for (int j = 0; j < 8; j++) c = c[15] ? {c[14:0], 1'b0} ^ 16'h1021 : {c[14:0], 1'b0};
    end
    return c;
  endfunction
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    print_verdict;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    // reset state, identity, gated commands outside debug mode
    i_host.send(CMD_CTL_RD);
    ex(8'h00);
    i_host.send(CMD_STATUS);
    ex(8'h20);
    i_host.send(CMD_VERSION);
    r16(16'h1234);
    i_host.send(8'h01);
    i_host.send(8'hc3);
    i_host.send(CMD_PC_RD);
    r16(16'hffff);
    mem(CMD_DATA_RD, 16'h0020, 16'h0001);
    ex(8'hff);
    i_host.send(CMD_CRC);
    r16(16'hffff);
    i_host.send(CMD_STEP);
    mem(CMD_DATA_WR, 16'h0010, 16'h0001);
    i_host.send(8'ha5);
    i_host.send(CMD_EXEC);
    i_host.send(8'h3e);
    ctl(8'h00, 8'h00);
    chk("steps", 24'(n_step), 24'h0);
    chk("data write", wr_last, 24'h0);
    $display("test gated done");
    repeat (66000) @(posedge clk);
    i_host.send(CMD_RUNTIME);
    r16(16'hffff);
    $display("test runtime done");
    ctl(8'h80, 8'h80);
    chk("cpu stop", {23'h0, stop}, 24'h1);
    i_host.send(CMD_STATUS);
    ex(8'ha0);
    i_host.send(CMD_PC_RD);
    r16(16'habcd);
    i_host.send(CMD_PC_WR);
    w16(16'h1234);
    repeat (4) @(posedge clk);
    chk("pc load", {8'(n_load), pc}, 24'h011234);
    mem(CMD_DATA_WR, 16'h0010, 16'h0001);
    i_host.send(8'ha5);
    repeat (8) @(posedge clk);
    chk("data write", wr_last, 24'h0010a5);
    mem(CMD_PROG_WR, 16'h0030, 16'h0001);
    i_host.send(8'h11);
    repeat (8) @(posedge clk);
    chk("locked write", wr_last, 24'h0010a5);
    unl <= 1'b1;
    mem(CMD_PROG_WR, 16'h0031, 16'h0001);
    i_host.send(8'h22);
    repeat (8) @(posedge clk);
    chk("prog write", wr_last, 24'h003122);
    mem(CMD_DATA_RD, 16'h0020, 16'h0002);
    r16(16'h7a7b);
    i_host.send(CMD_REG_RD);
    w16(16'h0ff0);
    i_host.send(8'h02);
    r16(16'haaab);
    i_host.send(CMD_STEP);
    i_host.send(CMD_STUFF);
    i_host.send(8'h3e);
    repeat (4) @(posedge clk);
    chk("step stuff", {8'(n_step), 8'(n_stuff), ins_seen}, 24'h01013e);
    ilast <= 1'b0;
    i_host.send(CMD_EXEC);
    i_host.send(8'h01);
    i_host.send(8'h02);
    ilast <= 1'b1;
    i_host.send(8'h03);
    repeat (4) @(posedge clk);
    chk("execute", {8'(n_inj), 8'h00, ins_seen}, 24'h030003);
    slow <= 1'b1;
    i_host.send(CMD_CRC);
    r16(crc_of(4));
    chk("crc space", {22'h0, sp_last}, 24'h000001);
    slow <= 1'b0;
    $display("test debug done");
    prot <= 1'b1;
    halted <= 1'b1;
    i_host.send(CMD_STATUS);
    ex(8'hc0);
    i_host.send(CMD_PC_RD);
    r16(16'hffff);
    mem(CMD_DATA_RD, 16'h0020, 16'h0001);
    ex(8'h7a);
    ctl(8'h00, 8'h80);
    i_host.send(CMD_STEP);
    repeat (4) @(posedge clk);
    chk("steps", 24'(n_step), 24'h1);
    prot <= 1'b0;
    halted <= 1'b0;
    $display("test protect done");
    ctl(8'h00, 8'h00);
    strobe(1'b1);
    ctl(8'h00, 8'h00);
    ctl(8'h60, 8'h60);
    strobe(1'b1);
    ex(ACK_BYTE);
    i_host.send(CMD_CTL_RD);
    ex(8'he0);
    $display("test break done");
    ctl(8'h81, 8'h81);
    chk("reset req", {23'h0, sreq}, 24'h1);
    strobe(1'b0);
    i_host.send(CMD_CTL_RD);
    ex(8'h80);
    ctl(8'h41, 8'h41);
    ctl(8'h40, 8'h40);
    ctl(8'h1e, 8'h00);
    chk("host hang", {23'h0, i_host.hung}, 24'h0);
    $display("test control done");
    print_verdict;
  end
endmodule // tb_dbgcu_top
`default_nettype wire
